// *** design/rfd_feedback_config.sv ***
// RF feedback divider configuration: serial word decode, pulse-swallow divider, timeout latch, power down
//
// Contract
// - Wide variant: swallow count is word bits 7:3, values 0 to 31.
// - Narrow variant: swallow count is word bits 6:3, values 0 to 15.
// - Narrow variant: binary count is word bits 21:7, values 3 to 32767, host never writes below 3.
// - Wide variant: binary count is word bits 21:8, values 3 to 16383, host never writes below 3.
// - Narrow variant: bit 22 picks prescaler 8/9 when 0 and 16/17 when 1.
// - Wide variant: bit 22 picks prescaler 16/17 when 0 and 32/33 when 1.
// - Bit 23 of the feedback word powers the RF loop down when 1 and keeps it active when 0.
// - Power down combines with the charge pump tri-state bit to choose synchronous or asynchronous power down.
// - Timeout word carries a 12-bit count at bits 14:3, upper data bits written as zero.
// - The divider uses swallow count, binary count and selected prescaler to form the feedback division.
// - A new timeout value is held and applied only at the next phase detector comparison event.
`timescale 1ns/10ps

`include "rfd_cfg.svh"

module rfd_feedback_config #(
    parameter bit WIDE_SWALLOW = 1'b0
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Three-wire serial programming pins
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_latch,
    // Loop events and reference word bit
    input  wire logic        prescaler_pulse,
    input  wire logic        pfd_event,
    input  wire logic        charge_pump_high_impedance,
    // Divider controls
    output logic             modulus_high,
    output logic             feedback_pulse,
    output logic             prescaler_ratio_select,
    output logic [5:0]       prescaler_low_modulus,
    output logic [14:0]      binary_count,
    output logic [4:0]       swallow_count,
    // Power and timeout state
    output logic             rf_loop_power_down,
    output logic             rf_loop_powered_down,
    output logic [11:0]      fastlock_timeout_count,
    output logic             timeout_pending
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Route a word by its address bits
    function automatic rfd_pkg::rfd_dest_t route_word(input logic [`RFD_WORD_W-1:0] w);
        unique case (w[`RFD_ADDR_MSB:0])
            `RFD_ADDR_FEEDBACK: route_word = rfd_pkg::RFD_DEST_FEEDBACK;
            `RFD_ADDR_TIMEOUT:  route_word = rfd_pkg::RFD_DEST_TIMEOUT;
            default:            route_word = rfd_pkg::RFD_DEST_NONE;
        endcase
    endfunction : route_word

    // Split a feedback word by variant
    function automatic rfd_pkg::rfd_feedback_t split_feedback(input logic [`RFD_WORD_W-1:0] w);
        rfd_pkg::rfd_feedback_t f;
        f.power_down   = w[`RFD_PD_BIT];
        f.ratio_select = w[`RFD_PSEL_BIT];
        if (WIDE_SWALLOW) begin
            f.binary_count  = {1'b0, w[`RFD_B_MSB:`RFD_B_LSB_WIDE]};
            f.swallow_count = w[`RFD_A_MSB_WIDE:`RFD_A_LSB];
        end else begin
            f.binary_count  = w[`RFD_B_MSB:`RFD_B_LSB_NARROW];
            f.swallow_count = {1'b0, w[`RFD_A_MSB_NARROW:`RFD_A_LSB]};
        end
        split_feedback = f;
    endfunction : split_feedback

    ////////////////////////////////////////////////////////////////////////////
    // Serial pin synchronisers and shift register

    logic [2:0]             pin_meta_reg;
    logic [2:0]             pin_sync_reg;
    logic [1:0]             pin_prev_reg;
    logic [`RFD_WORD_W-1:0] shift_reg;
    logic [`RFD_WORD_W-1:0] shift_next;
    logic                   clk_rise;
    logic                   latch_rise;

    // Two flip-flops on every pin before use
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            pin_prev_reg <= 2'h0;
            shift_reg    <= '0;
        end else begin
            pin_meta_reg <= {ser_latch, ser_clk, ser_data};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg[2:1];
            shift_reg    <= shift_next;
        end
    end

    // Shift in most significant bit first on each rising serial clock
    always_comb begin
        clk_rise   = pin_sync_reg[1] & ~pin_prev_reg[0];
        latch_rise = pin_sync_reg[2] & ~pin_prev_reg[1];
        shift_next = shift_reg;
        if (clk_rise) begin
            shift_next = {shift_reg[`RFD_WORD_W-2:0], pin_sync_reg[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Programmed words, timeout latch and power down

    rfd_pkg::rfd_feedback_t fb_reg;
    rfd_pkg::rfd_feedback_t fb_next;
    logic [11:0]            toc_hold_reg;
    logic [11:0]            toc_hold_next;
    logic [11:0]            toc_reg;
    logic [11:0]            toc_next;
    logic                   pend_reg;
    logic                   pend_next;
    logic                   down_reg;
    logic                   down_next;
    rfd_pkg::rfd_dest_t     dest;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fb_reg       <= '{power_down: 1'b0, ratio_select: 1'b0,
                              binary_count: `RFD_RST_B, swallow_count: `RFD_RST_A};
            toc_hold_reg <= `RFD_RST_TOC;
            toc_reg      <= `RFD_RST_TOC;
            pend_reg     <= 1'b0;
            down_reg     <= 1'b0;
        end else begin
            fb_reg       <= fb_next;
            toc_hold_reg <= toc_hold_next;
            toc_reg      <= toc_next;
            pend_reg     <= pend_next;
            down_reg     <= down_next;
        end
    end

    // Word routing, deferred timeout and power-down mode
    always_comb begin
        dest          = latch_rise ? route_word(shift_reg) : rfd_pkg::RFD_DEST_NONE;
        fb_next       = fb_reg;
        toc_hold_next = toc_hold_reg;
        toc_next      = toc_reg;
        pend_next     = pend_reg;
        if (dest == rfd_pkg::RFD_DEST_FEEDBACK) begin
            fb_next = split_feedback(shift_reg);
        end
        // Held value moves over on a comparison event
        if (pfd_event && pend_reg) begin
            toc_next  = toc_hold_reg;
            pend_next = 1'b0;
        end
        // A new write wins over the event that clears the flag
        if (dest == rfd_pkg::RFD_DEST_TIMEOUT) begin
            toc_hold_next = shift_reg[`RFD_TOC_MSB:`RFD_TOC_LSB];
            pend_next     = 1'b1;
        end
        // Tri-state set: asynchronous, else wait for a comparison event
        down_next = down_reg;
        if (!fb_reg.power_down) begin
            down_next = 1'b0;
        end else if (charge_pump_high_impedance || pfd_event) begin
            down_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse-swallow feedback divider

    logic [14:0] b_cnt_reg;
    logic [14:0] b_cnt_next;
    logic [4:0]  a_cnt_reg;
    logic [4:0]  a_cnt_next;
    logic        fbp_reg;
    logic        fbp_next;
    logic        hold_div;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            b_cnt_reg <= `RFD_RST_B;
            a_cnt_reg <= `RFD_RST_A;
            fbp_reg   <= 1'b0;
        end else begin
            b_cnt_reg <= b_cnt_next;
            a_cnt_reg <= a_cnt_next;
            fbp_reg   <= fbp_next;
        end
    end

    // Prescaler runs high modulus for A pulses, low for B minus A, B pulses a cycle
    always_comb begin
        hold_div   = down_reg;
        b_cnt_next = b_cnt_reg;
        a_cnt_next = a_cnt_reg;
        fbp_next   = 1'b0;
        if (hold_div) begin
            b_cnt_next = fb_reg.binary_count;
            a_cnt_next = fb_reg.swallow_count;
        end else if (prescaler_pulse) begin
            if (b_cnt_reg <= 15'h0001) begin
                b_cnt_next = fb_reg.binary_count;
                a_cnt_next = fb_reg.swallow_count;
                fbp_next   = 1'b1;
            end else begin
                b_cnt_next = b_cnt_reg - 15'h0001;
                if (a_cnt_reg != 5'h00) begin
                    a_cnt_next = a_cnt_reg - 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign modulus_high           = ~down_reg && (a_cnt_reg != 5'h00);
    assign feedback_pulse         = fbp_reg;
    assign prescaler_ratio_select = fb_reg.ratio_select;
    assign prescaler_low_modulus  = WIDE_SWALLOW ?
        (fb_reg.ratio_select ? `RFD_PRE_WIDE_HI : `RFD_PRE_WIDE_LO) :
        (fb_reg.ratio_select ? `RFD_PRE_NARROW_HI : `RFD_PRE_NARROW_LO);
    assign binary_count           = fb_reg.binary_count;
    assign swallow_count          = fb_reg.swallow_count;
    assign rf_loop_power_down     = fb_reg.power_down;
    assign rf_loop_powered_down   = down_reg;
    assign fastlock_timeout_count = toc_reg;
    assign timeout_pending        = pend_reg;

endmodule : rfd_feedback_config

// *** include/rfd_cfg.svh ***
// Constants for the RF feedback divider configuration block
`ifndef RFD_CFG_SVH
`define RFD_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Serial word layout
`define RFD_WORD_W          24
`define RFD_ADDR_MSB        2
`define RFD_ADDR_FEEDBACK   3'h1
`define RFD_ADDR_TIMEOUT    3'h2

////////////////////////////////////////////////////////////////////////////////
// Feedback word fields
`define RFD_PD_BIT          23
`define RFD_PSEL_BIT        22
`define RFD_B_MSB           21
`define RFD_B_LSB_NARROW    7
`define RFD_B_LSB_WIDE      8
`define RFD_A_LSB           3
`define RFD_A_MSB_NARROW    6
`define RFD_A_MSB_WIDE      7
`define RFD_B_MIN           15'h0003

////////////////////////////////////////////////////////////////////////////////
// Timeout word fields
`define RFD_TOC_MSB         14
`define RFD_TOC_LSB         3

////////////////////////////////////////////////////////////////////////////////
// Prescaler low moduli: narrow variant 8 or 16, wide variant 16 or 32
`define RFD_PRE_NARROW_LO   6'h08
`define RFD_PRE_NARROW_HI   6'h10
`define RFD_PRE_WIDE_LO     6'h10
`define RFD_PRE_WIDE_HI     6'h20

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RFD_RST_B           15'h0003
`define RFD_RST_A           5'h00
`define RFD_RST_TOC         12'h000

`endif

// *** include/rfd_pkg.sv ***
// Types shared by the RF feedback divider configuration block
package rfd_pkg;

    // Decoded feedback word
    typedef struct packed {
        logic        power_down;
        logic        ratio_select;
        logic [14:0] binary_count;
        logic [4:0]  swallow_count;
    } rfd_feedback_t;

    // Destination of a latched serial word
    typedef enum logic [2:0] {
        RFD_DEST_NONE     = 3'b001,
        RFD_DEST_FEEDBACK = 3'b010,
        RFD_DEST_TIMEOUT  = 3'b100
    } rfd_dest_t;

endpackage : rfd_pkg

// *** test/rfd_cfg_monitor.sv ***
// Assertion checker bound to the configuration block
`timescale 1ns/10ps
module rfd_cfg_monitor #(
    parameter bit WIDE_SWALLOW = 1'b0
) (
    // Clock, reset and loop inputs
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        prescaler_pulse,
    input wire logic        pfd_event,
    input wire logic        charge_pump_high_impedance,
    // Watched outputs
    input wire logic        feedback_pulse,
    input wire logic        prescaler_ratio_select,
    input wire logic [5:0]  prescaler_low_modulus,
    input wire logic        rf_loop_power_down,
    input wire logic        rf_loop_powered_down,
    input wire logic [11:0] fastlock_timeout_count,
    input wire logic        timeout_pending
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and power down
    low_modulus_a: assert property (prescaler_low_modulus == (WIDE_SWALLOW ?
        (prescaler_ratio_select ? 6'h20 : 6'h10) : (prescaler_ratio_select ? 6'h10 : 6'h08)))
        else $error("low modulus wrong");
    pd_release_a: assert property (!rf_loop_power_down |=> !rf_loop_powered_down)
        else $error("power down not released");
    async_down_a: assert property (rf_loop_power_down && charge_pump_high_impedance |=> rf_loop_powered_down)
        else $error("async power down late");
    sync_down_a: assert property ($rose(rf_loop_powered_down) && !$past(charge_pump_high_impedance)
        |-> $past(pfd_event) || $past(pfd_event, 2)) else $error("sync power down without event");
    ////////////////////////////////////////////////////////////////////////////
    // Timeout latch and divider
    toc_hold_a: assert property ($changed(fastlock_timeout_count) |-> $past(pfd_event) || $past(pfd_event, 2))
        else $error("timeout applied without event");
    pend_fall_a: assert property ($fell(timeout_pending) |-> $past(pfd_event) || $past(pfd_event, 2))
        else $error("pending cleared without event");
    fb_single_a: assert property (feedback_pulse |=> !feedback_pulse)
        else $error("feedback pulse too long");
    fb_cause_a: assert property (feedback_pulse |-> $past(prescaler_pulse) && !$past(rf_loop_powered_down))
        else $error("feedback pulse without cause");
    cover property (feedback_pulse);
    cover property ($rose(rf_loop_powered_down));
    cover property ($fell(timeout_pending));
endmodule : rfd_cfg_monitor

bind rfd_feedback_config rfd_cfg_monitor #(.WIDE_SWALLOW(WIDE_SWALLOW)) u_mon (.core_clk, .reset,
    .prescaler_pulse, .pfd_event, .charge_pump_high_impedance, .feedback_pulse, .prescaler_ratio_select,
    .prescaler_low_modulus, .rf_loop_power_down, .rf_loop_powered_down, .fastlock_timeout_count, .timeout_pending);

// *** test/rfd_feedback_config_tb.sv ***
// Self-checking testbench for the configuration block
`timescale 1ns/10ps
module rfd_feedback_config_tb;
    logic core_clk, reset, ser_clk, ser_data, ser_latch, prescaler_pulse, pfd_event, charge_pump_high_impedance;
    logic modulus_high, feedback_pulse, prescaler_ratio_select, rf_loop_power_down, rf_loop_powered_down;
    logic timeout_pending, start, busy;
    logic [5:0]  prescaler_low_modulus;
    logic [14:0] binary_count;
    logic [4:0]  swallow_count;
    logic [11:0] fastlock_timeout_count;
    logic [23:0] word;
    logic        w_modulus_high, w_feedback_pulse;
    logic [5:0]  w_prescaler_low_modulus;
    logic [14:0] w_binary_count;
    logic [4:0]  w_swallow_count;
    int          fail_count, samples_checked;

    rfd_feedback_config #(.WIDE_SWALLOW(1'b0)) DUT (.core_clk, .reset, .ser_clk, .ser_data, .ser_latch,
        .prescaler_pulse, .pfd_event, .charge_pump_high_impedance, .modulus_high, .feedback_pulse,
        .prescaler_ratio_select, .prescaler_low_modulus, .binary_count, .swallow_count, .rf_loop_power_down,
        .rf_loop_powered_down, .fastlock_timeout_count, .timeout_pending);
    rfd_host_model HOST (.core_clk, .start, .word, .ser_clk, .ser_data, .ser_latch, .busy);
    // Wide-swallow variant sees the same words and loop events
    rfd_feedback_config #(.WIDE_SWALLOW(1'b1)) DUT_WIDE (.core_clk, .reset, .ser_clk, .ser_data, .ser_latch,
        .prescaler_pulse, .pfd_event, .charge_pump_high_impedance, .modulus_high(w_modulus_high),
        .feedback_pulse(w_feedback_pulse), .prescaler_ratio_select(), .prescaler_low_modulus(w_prescaler_low_modulus),
        .binary_count(w_binary_count), .swallow_count(w_swallow_count), .rf_loop_power_down(),
        .rf_loop_powered_down(), .fastlock_timeout_count(), .timeout_pending());

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task finish_test;
        $display("Checked %0d, errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [23:0] w);
        int n;
        @(posedge core_clk);
        #1 word = w;
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        for (n = 0; busy === 1'b1 && n < 400; n++) @(posedge core_clk);
        if (n >= 400) begin
            fail_count++;
            $display("Error at %0t: busy %h expected %h", $time, busy, 1'b0);
            finish_test();
        end
        repeat (3) @(posedge core_clk);
        #1;
    endtask : wr

    task pfd;
        pfd_event = 1'b1;
        @(posedge core_clk);
        #1 pfd_event = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : pfd
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_div(input int b, input int a, input int wb, input int wa);
        int s = 0, h = 0, c = 0, ws = 0, wh = 0, wc = 0;
        prescaler_pulse = 1'b1;
        for (int k = 0; k < 200 && (c < 2 || wc < 2); k++) begin
            @(posedge core_clk);
            #2;
            if (feedback_pulse === 1'b1) c++;
            if (w_feedback_pulse === 1'b1) wc++;
            if (c == 1) begin
                s++;
                h += (modulus_high === 1'b1);
            end
            if (wc == 1) begin
                ws++;
                wh += (w_modulus_high === 1'b1);
            end
        end
        @(posedge core_clk);
        #1 prescaler_pulse = 1'b0;
        chk(s, b);
        chk(h, a);
        chk(ws, wb);
        chk(wh, wa);
    endtask : t_div

    task t_fields;
        wr({2'b01, 15'h7fff, 4'hf, 3'h1});
        chk({binary_count, swallow_count}, {15'h7fff, 5'h0f});
        chk(w_binary_count, 15'h3fff);
        chk(w_swallow_count, 5'h1f);
        chk({prescaler_ratio_select, prescaler_low_modulus}, {1'b1, 6'h10});
        chk(w_prescaler_low_modulus, 6'h20);
        wr({2'b01, 15'h1234, 4'h5, 3'h3});
        chk(binary_count, 15'h7fff);
        chk(w_binary_count, 15'h3fff);
        wr({2'b00, 15'h0006, 4'h3, 3'h1});
        chk({swallow_count, prescaler_low_modulus}, {5'h03, 6'h08});
        chk({w_swallow_count, w_prescaler_low_modulus}, {5'h03, 6'h10});
        chk(w_binary_count, 15'h0003);
        t_div(6, 3, 3, 3);
        wr({2'b01, 15'h0028, 4'hf, 3'h1});
        t_div(40, 15, 20, 15);
    endtask : t_fields

    task t_toc;
        wr({9'h000, 12'hfff, 3'h2});
        chk({timeout_pending, fastlock_timeout_count}, {1'b1, 12'h000});
        pfd();
        chk({timeout_pending, fastlock_timeout_count}, {1'b0, 12'hfff});
    endtask : t_toc

    task t_pd;
        charge_pump_high_impedance = 1'b1;
        wr({2'b10, 15'h0010, 4'h2, 3'h1});
        chk({rf_loop_power_down, rf_loop_powered_down}, 2'b11);
        wr({2'b00, 15'h0010, 4'h2, 3'h1});
        chk(rf_loop_powered_down, 1'b0);
        charge_pump_high_impedance = 1'b0;
        wr({2'b10, 15'h0010, 4'h2, 3'h1});
        chk(rf_loop_powered_down, 1'b0);
        pfd();
        chk(rf_loop_powered_down, 1'b1);
    endtask : t_pd

    // Main sequence
    initial begin
        {reset, start, prescaler_pulse, pfd_event, charge_pump_high_impedance} = 5'h10;
        word = 24'h000000;
        fail_count = 0;
        samples_checked = 0;
        repeat (6) @(posedge core_clk);
        #1 reset = 1'b0;
        chk({binary_count, prescaler_low_modulus}, {15'h0003, 6'h08});
        chk(w_prescaler_low_modulus, 6'h10);
        t_fields();
        t_toc();
        t_pd();
        finish_test();
    end
endmodule : rfd_feedback_config_tb

// *** test/rfd_host_model.sv ***
// Host model that shifts 24-bit programming words into the block
`timescale 1ns/10ps
module rfd_host_model (
    // Clock and command
    input  wire logic        core_clk,
    input  wire logic        start,
    input  wire logic [23:0] word,
    // Serial pins and status
    output logic             ser_clk,
    output logic             ser_data,
    output logic             ser_latch,
    output logic             busy
);
    // Wait n edges, then step off the edge
    task hold(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : hold

    // Serial clock parked low between frames
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
        busy = 1'b0;
    end

    // MSB first, each serial clock level held four cycles, each data bit eight, latch after the last bit
    always begin
        @(posedge core_clk);
        if (start) begin
            busy = 1'b1;
            #1;
            for (int i = 23; i >= 0; i--) begin
                ser_data = word[i];
                hold(4);
                ser_clk = 1'b1;
                hold(4);
                ser_clk = 1'b0;
            end
            hold(4);
            ser_latch = 1'b1;
            hold(4);
            ser_latch = 1'b0;
            ser_data = ~ser_data; // Released line shows the inverse
            busy = 1'b0;
        end
    end
endmodule : rfd_host_model
